//--- design/dspr_sweep_top.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
// Notes on behaviour
// RQ1 - 2-level aux ramp: profile line n drives channel n
// RQ2 - aux 1,2 pick channel; aux 3 picks direction
// RQ3 - 4-level: config field picks channel pair
// RQ4 - 4-level: line pair selects one of four profiles
// RQ5 - 4-level: aux 1 first, aux 2 second channel
// RQ6 - 16-level: low config bits pick one channel
// RQ7 - 16-level: four lines index sixteen profiles
// RQ8 - sweep start profile 0, end profile 1
// RQ9 - end value msb-aligned by sweep quantity
// RQ10 - profile line n triggers channel n sweep
// RQ11 - quantity field picks amplitude, frequency, phase
// RQ12 - software keeps sweep channels at 2-level
// RQ13 - aux or spare lines ramp amplitude around sweep
// RQ14 - rise uses rising words, fall uses falling
// RQ15 - step words by quantity, intervals 8 bits
// RQ16 - no-dwell returns to zero, else holds
// RQ17 - step and interval rewrites allowed mid-sweep
// RQ18 - each rising step adds, each falling step subtracts, step word in accumulator
// RQ19 - interval of 1 to 256 sync periods
// RQ20 - 8-bit down timer reloads at 1
// RQ21 - profile edge reloads rising or falling interval
// RQ22 - update strobe reloads interval by line level
// RQ23 - sweep stops and holds at end or start
// RQ24 - ramp field 11 dedicates aux, 1-bit serial
// RQ25 - lines registered and edge-detected before use; profile edges compare the live lines with their registered copy
module dspr_sweep_top
	import dspr_pkg::*;
#(
	parameter int NCH = DSPR_NCH
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] profile_line, // profile select lines
	input wire logic [2:0] aux_line, // auxiliary lines 1..3
	input wire logic update_strobe, // external update
	output logic [NCH-1:0][31:0] sweep_word, // accumulator out
	output logic [NCH-1:0][3:0] profile_index, // selected profile
	output logic [NCH-1:0] ramp_active, // ramp control owned
	output logic [NCH-1:0] ramp_down, // ramp direction
	output logic serial_one_bit // serial port forced 1-bit
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		dspr_wst_t wst; // write fsm
		logic [7:0] waddr; // latched write address
		logic aw_got; // address held
		logic [31:0] wdata; // latched write data
		logic w_got; // data held
		logic bvalid; // write response
		logic rvalid; // read data valid
		logic [31:0] rdata; // read data
		logic [1:0] rresp; // read response
		logic [1:0] bresp; // write response code
		logic [1:0] chsel; // channel targeted by writes
		logic [31:0] func_one; // function reg one
		logic sw_update; // software update pulse
		dspr_chregs_t [NCH-1:0] ch; // per channel registers
		logic [3:0] prof_q; // registered profile lines
		logic [2:0] aux_q; // registered aux lines
		logic upd_q; // registered update
		logic [NCH-1:0][7:0] timer; // ramp rate timers
		logic [NCH-1:0][31:0] acc; // sweep accumulators
		logic [NCH-1:0] at_end; // sweep reached target
		logic [NCH-1:0][3:0] pidx; // profile index out
		logic [NCH-1:0] ract; // ramp owned
		logic [NCH-1:0] rdn; // ramp direction
		logic one_bit; // serial restricted
	} dspr_state_t;

	dspr_state_t s_q, s_d;
	logic [1:0] lvl; // modulation level field
	logic [1:0] ramp_f; // amplitude ramp field
	logic [2:0] pin_to_channel_config; // pin-to-channel field
	logic wr_fire; // write address and data both held
	logic [7:0] widx; // write register index
	logic [7:0] ridx; // read register index
	logic [NCH-1:0] rise_e, fall_e; // profile edges
	logic upd; // any update source

	assign lvl = s_q.func_one[DSPR_F1_LEVEL_LSB +: 2];
	assign ramp_f = s_q.func_one[DSPR_F1_RAMP_LSB +: 2];
	assign pin_to_channel_config = s_q.func_one[DSPR_F1_PPC_LSB +: 3];
	assign wr_fire = s_q.aw_got && s_q.w_got;
	assign widx = {2'h0, s_q.waddr[7:2]};
	assign ridx = {2'h0, s_axi_araddr[7:2]};
	assign upd = s_q.upd_q || s_q.sw_update;

	// ------------------------------------------------------------
	// edge detect: live profile lines against their registered copy
	// ------------------------------------------------------------
	assign rise_e = profile_line & ~s_q.prof_q; // RQ25
	assign fall_e = ~profile_line & s_q.prof_q; // RQ25

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [31:0] step; // current step word
		logic [31:0] lim; // target value
		logic [31:0] msk; // width mask by quantity
		logic [31:0] nxt; // next accumulator value
		logic [1:0] q; // quantity
		logic [1:0] pa, pb; // pair channels
		step = DSPR_RST_WORD;
		lim = DSPR_RST_WORD;
		msk = DSPR_RST_WORD;
		nxt = DSPR_RST_WORD;
		q = 2'h0;
		pa = 2'h0;
		pb = 2'h0;
		s_d = s_q;
		s_d.sw_update = 1'b0;
		// input registers for edge detection
		s_d.prof_q = profile_line; // RQ25
		s_d.aux_q = aux_line; // RQ25
		s_d.upd_q = update_strobe; // RQ25
		// write channel capture, either order
		if (s_axi_awvalid && !s_q.aw_got)
		begin
			s_d.aw_got = 1'b1;
			s_d.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_got)
		begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata;
		end
		case (s_q.wst)
			DSPR_WR_IDLE:
			begin
				if (wr_fire)
				begin
					// register writes accepted anytime
					s_d.bresp = 2'h0;
					case (widx)
						DSPR_IDX_CHAN_SEL: s_d.chsel = s_q.wdata[1:0];
						DSPR_IDX_FUNC_ONE: s_d.func_one = s_q.wdata;
						DSPR_IDX_CHAN_FN: s_d.ch[s_q.chsel].chan_fn = s_q.wdata;
						DSPR_IDX_START_VAL:
							s_d.ch[s_q.chsel].start_val = s_q.wdata; // RQ8
						DSPR_IDX_INTERVAL:
							s_d.ch[s_q.chsel].interval = s_q.wdata[15:0]; // RQ17
						DSPR_IDX_RISE_STEP:
							s_d.ch[s_q.chsel].rise_step = s_q.wdata; // RQ17
						DSPR_IDX_FALL_STEP:
							s_d.ch[s_q.chsel].fall_step = s_q.wdata; // RQ17
						DSPR_IDX_END_VAL:
							s_d.ch[s_q.chsel].end_val = s_q.wdata; // RQ8
						DSPR_IDX_UPDATE: s_d.sw_update = s_q.wdata[0];
						DSPR_IDX_STATUS: s_d.bresp = 2'h0;
						default: s_d.bresp = 2'h2;
					endcase
					s_d.aw_got = 1'b0;
					s_d.w_got = 1'b0;
					s_d.bvalid = 1'b1;
					s_d.wst = DSPR_WR_RESP;
				end
			end
			DSPR_WR_RESP:
			begin
				if (s_axi_bready)
				begin
					s_d.bvalid = 1'b0;
					s_d.wst = DSPR_WR_HOLD;
				end
			end
			DSPR_WR_HOLD: s_d.wst = DSPR_WR_IDLE;
			default: s_d.wst = DSPR_WR_IDLE;
		endcase
		// read channel: one cycle latency
		if (s_q.rvalid)
		begin
			if (s_axi_rready)
				s_d.rvalid = 1'b0;
		end
		else if (s_axi_arvalid)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp = 2'h0;
			case (ridx)
				DSPR_IDX_CHAN_SEL: s_d.rdata = {30'h0000_0000, s_q.chsel};
				DSPR_IDX_FUNC_ONE: s_d.rdata = s_q.func_one;
				DSPR_IDX_CHAN_FN: s_d.rdata = s_q.ch[s_q.chsel].chan_fn;
				DSPR_IDX_START_VAL: s_d.rdata = s_q.ch[s_q.chsel].start_val;
				DSPR_IDX_INTERVAL:
					s_d.rdata = {16'h0000, s_q.ch[s_q.chsel].interval};
				DSPR_IDX_RISE_STEP: s_d.rdata = s_q.ch[s_q.chsel].rise_step;
				DSPR_IDX_FALL_STEP: s_d.rdata = s_q.ch[s_q.chsel].fall_step;
				DSPR_IDX_END_VAL: s_d.rdata = s_q.ch[s_q.chsel].end_val;
				DSPR_IDX_STATUS:
					s_d.rdata = {20'h0_0000, s_q.at_end, 8'h00};
				DSPR_IDX_UPDATE: s_d.rdata = DSPR_RST_WORD;
				default:
				begin
					s_d.rdata = DSPR_RST_WORD;
					s_d.rresp = 2'h2;
				end
			endcase
		end
		// per-channel sweep engine
		for (int i = 0; i < NCH; i++)
		begin
			q = s_q.ch[i].chan_fn[DSPR_CF_QTY_LSB +: 2]; // RQ11
			// width mask: msb-aligned, low bits ignored
			case (q)
				DSPR_QTY_AMP: msk = {{DSPR_AMP_W{1'b1}}, 22'h00_0000}; // RQ9
				DSPR_QTY_PHASE: msk = {{DSPR_PHASE_W{1'b1}}, 18'h0_0000}; // RQ9
				DSPR_QTY_FREQ: msk = 32'hffff_ffff; // RQ15
				default: msk = DSPR_RST_WORD;
			endcase
			if (s_q.ch[i].chan_fn[DSPR_CF_SWEEP_EN] && q != DSPR_QTY_NONE)
			begin
				// line n steers channel n
				if (rise_e[i])
				begin
					s_d.timer[i] = s_q.ch[i].interval[7:0]; // RQ21
					s_d.at_end[i] = 1'b0;
				end
				else if (fall_e[i])
				begin
					s_d.timer[i] = s_q.ch[i].interval[15:8]; // RQ21
					s_d.at_end[i] = 1'b0;
				end
				else if (upd)
				begin
					s_d.timer[i] = s_q.prof_q[i] ? s_q.ch[i].interval[7:0]
						: s_q.ch[i].interval[15:8]; // RQ22
				end
				else if (s_q.timer[i] == 8'h01)
				begin
					// timer expiry at 1; a load of 0 wraps, giving 256
					s_d.timer[i] = s_q.prof_q[i] ? s_q.ch[i].interval[7:0]
						: s_q.ch[i].interval[15:8]; // RQ20 RQ19
					step = (s_q.prof_q[i] ? s_q.ch[i].rise_step
						: s_q.ch[i].fall_step) & msk; // RQ14 RQ15
					lim = (s_q.prof_q[i] ? s_q.ch[i].end_val
						: s_q.ch[i].start_val) & msk; // RQ8 RQ9
					// no-dwell: rest at zero until the next rising edge
					if (s_q.prof_q[i] && s_q.at_end[i]
						&& s_q.ch[i].chan_fn[DSPR_CF_NODWELL])
						s_d.acc[i] = s_q.acc[i]; // RQ16
					else if (s_q.prof_q[i])
					begin
						nxt = s_q.acc[i] + step; // RQ18
						if (s_q.acc[i] >= lim || nxt < s_q.acc[i] || nxt >= lim)
						begin
							// no-dwell drops to zero, else hold
							s_d.acc[i] = s_q.ch[i].chan_fn[DSPR_CF_NODWELL]
								? DSPR_RST_WORD : lim; // RQ16 RQ23
							s_d.at_end[i] = 1'b1;
						end
						else
							s_d.acc[i] = nxt; // RQ10
					end
					else if (!s_q.ch[i].chan_fn[DSPR_CF_NODWELL])
					begin
						nxt = s_q.acc[i] - step; // RQ18
						if (s_q.acc[i] <= lim || nxt > s_q.acc[i] || nxt <= lim)
						begin
							s_d.acc[i] = lim; // RQ23
							s_d.at_end[i] = 1'b1;
						end
						else
							s_d.acc[i] = nxt;
					end
				end
				else
					s_d.timer[i] = s_q.timer[i] - 8'h01; // RQ20
				s_d.pidx[i] = {3'h0, s_q.prof_q[i]};
			end
			else
			begin
				s_d.timer[i] = DSPR_RST_TIMER;
				s_d.pidx[i] = 4'h0;
			end
			s_d.ract[i] = 1'b0;
			s_d.rdn[i] = 1'b0;
		end
		// routing of profile and aux lines with ramp field 11
		s_d.one_bit = (ramp_f == 2'h3); // RQ24
		if (ramp_f == 2'h3)
		begin
			case (lvl)
				DSPR_LVL_2:
				begin
					// profile line n to channel n
					for (int i = 0; i < NCH; i++)
						if (!s_q.ch[i].chan_fn[DSPR_CF_SWEEP_EN])
							s_d.pidx[i] = {3'h0, s_q.prof_q[i]}; // RQ1
					s_d.ract[{s_q.aux_q[0], s_q.aux_q[1]}] = 1'b1; // RQ2 RQ13
					s_d.rdn[{s_q.aux_q[0], s_q.aux_q[1]}] = s_q.aux_q[2]; // RQ2
				end
				DSPR_LVL_4:
				begin
					case (pin_to_channel_config)
						3'h0: begin pa = 2'h0; pb = 2'h1; end // RQ3
						3'h1: begin pa = 2'h0; pb = 2'h2; end
						3'h2: begin pa = 2'h0; pb = 2'h3; end
						3'h3: begin pa = 2'h1; pb = 2'h2; end
						3'h4: begin pa = 2'h1; pb = 2'h3; end
						default: begin pa = 2'h2; pb = 2'h3; end
					endcase
					s_d.pidx[pa] = {2'h0, s_q.prof_q[0], s_q.prof_q[1]}; // RQ4
					s_d.pidx[pb] = {2'h0, s_q.prof_q[2], s_q.prof_q[3]}; // RQ4
					s_d.ract[pa] = 1'b1; // RQ5
					s_d.rdn[pa] = s_q.aux_q[0]; // RQ5
					s_d.ract[pb] = 1'b1; // RQ5
					s_d.rdn[pb] = s_q.aux_q[1]; // RQ5
				end
				DSPR_LVL_16:
				begin
					s_d.pidx[pin_to_channel_config[1:0]] = {s_q.prof_q[0], s_q.prof_q[1],
						s_q.prof_q[2], s_q.prof_q[3]}; // RQ6 RQ7
					s_d.ract[pin_to_channel_config[1:0]] = 1'b1; // RQ6
					s_d.rdn[pin_to_channel_config[1:0]] = s_q.aux_q[0]; // RQ6
				end
				default: s_d.one_bit = 1'b1;
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register, synchronous reset
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= '0;
			s_q.wst <= DSPR_WR_IDLE;
			for (int i = 0; i < NCH; i++)
				s_q.timer[i] <= DSPR_RST_TIMER;
		end
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------
	// outputs, straight from flops
	// ------------------------------------------------------------
	assign s_axi_awready = !s_q.aw_got;
	assign s_axi_wready = !s_q.w_got;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign sweep_word = s_q.acc;
	assign profile_index = s_q.pidx;
	assign ramp_active = s_q.ract;
	assign ramp_down = s_q.rdn;
	assign serial_one_bit = s_q.one_bit;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_rise_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.ch[1].chan_fn[DSPR_CF_SWEEP_EN] && rise_e[1]
		&& s_q.ch[1].chan_fn[23:22] != 2'h0)
		|=> s_q.timer[1] == $past(s_q.ch[1].interval[7:0])) // RQ21
		else $error("rising edge did not load rising interval");
	a_fall_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.ch[1].chan_fn[DSPR_CF_SWEEP_EN] && fall_e[1]
		&& s_q.ch[1].chan_fn[23:22] != 2'h0)
		|=> s_q.timer[1] == $past(s_q.ch[1].interval[15:8])) // RQ21
		else $error("falling edge did not load falling interval");
	a_update_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.ch[1].chan_fn[DSPR_CF_SWEEP_EN] && upd && s_q.prof_q[1]
		&& !rise_e[1] && !fall_e[1] && s_q.ch[1].chan_fn[23:22] != 2'h0)
		|=> s_q.timer[1] == $past(s_q.ch[1].interval[7:0])) // RQ22
		else $error("update did not load rising interval");
	a_timer_count: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.ch[1].chan_fn[DSPR_CF_SWEEP_EN] && s_q.timer[1] > 8'h01
		&& !rise_e[1] && !fall_e[1] && !upd
		&& s_q.ch[1].chan_fn[23:22] != 2'h0)
		|=> s_q.timer[1] == $past(s_q.timer[1]) - 8'h01) // RQ20
		else $error("timer did not count down");
	a_serial_bit: assert property (@(posedge aclk) disable iff (!aresetn)
		(ramp_f == 2'h3) |=> serial_one_bit) // RQ24
		else $error("serial port not restricted");
	a_two_lvl_aux: assert property (@(posedge aclk) disable iff (!aresetn)
		(ramp_f == 2'h3 && lvl == 2'h0 && s_q.aux_q == 3'h7)
		|=> ramp_active[3] && ramp_down[3]) // RQ2
		else $error("aux lines misrouted in 2-level");
	a_quad_pidx: assert property (@(posedge aclk) disable iff (!aresetn)
		(ramp_f == 2'h3 && lvl == 2'h3 && pin_to_channel_config[1:0] == 2'h2)
		|=> profile_index[2] == $past({s_q.prof_q[0], s_q.prof_q[1],
		s_q.prof_q[2], s_q.prof_q[3]})) // RQ7
		else $error("16-level profile index wrong");
	a_pair_route: assert property (@(posedge aclk) disable iff (!aresetn)
		(ramp_f == 2'h3 && lvl == 2'h1 && pin_to_channel_config == 3'h5)
		|=> ramp_down[3] == $past(s_q.aux_q[1])) // RQ5
		else $error("4-level second channel ramp wrong");
	a_hold_end: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_q.at_end[1] && s_q.prof_q[1] && profile_line[1]
		&& !s_q.ch[1].chan_fn[DSPR_CF_NODWELL]
		&& $stable(s_q.ch[1].end_val))
		|=> $stable(sweep_word[1])) // RQ23
		else $error("sweep did not hold at end");
	c_sweep_done: cover property (@(posedge aclk) $rose(s_q.at_end[1]));
	c_update_hit: cover property (@(posedge aclk) upd && s_q.ch[1].chan_fn[14]);
	c_axi_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);

endmodule : dspr_sweep_top

//--- inc/dspr_pkg.sv
package dspr_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses = index * 4)
	// ------------------------------------------------------------
	localparam logic [7:0] DSPR_IDX_INTERVAL = 8'h07; // interval pair
	localparam logic [7:0] DSPR_IDX_RISE_STEP = 8'h08; // rising step word
	localparam logic [7:0] DSPR_IDX_FALL_STEP = 8'h09; // falling step word
	localparam logic [7:0] DSPR_IDX_END_VAL = 8'h0a; // sweep end value
	localparam logic [7:0] DSPR_IDX_START_VAL = 8'h04; // profile reg 0
	localparam logic [7:0] DSPR_IDX_CHAN_FN = 8'h03; // channel function
	localparam logic [7:0] DSPR_IDX_FUNC_ONE = 8'h01; // function reg one
	localparam logic [7:0] DSPR_IDX_CHAN_SEL = 8'h00; // channel select
	localparam logic [7:0] DSPR_IDX_STATUS = 8'h10; // sweep status
	localparam logic [7:0] DSPR_IDX_UPDATE = 8'h11; // update strobe

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int DSPR_CF_QTY_LSB = 22; // sweep quantity select
	localparam int DSPR_CF_NODWELL = 15; // no-dwell option
	localparam int DSPR_CF_SWEEP_EN = 14; // sweep enable bit
	localparam int DSPR_F1_LEVEL_LSB = 8; // modulation level
	localparam int DSPR_F1_RAMP_LSB = 10; // amplitude ramp field
	localparam int DSPR_F1_PPC_LSB = 12; // pin to channel config

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int DSPR_NCH = 4; // channel count
	localparam int DSPR_FREQ_W = 32; // frequency resolution
	localparam int DSPR_PHASE_W = 14; // phase resolution
	localparam int DSPR_AMP_W = 10; // amplitude resolution
	localparam logic [31:0] DSPR_RST_WORD = 32'h0000_0000; // reset value
	localparam logic [7:0] DSPR_RST_TIMER = 8'h01; // timer idle value

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DSPR_QTY_NONE = 2'h0,
		DSPR_QTY_AMP = 2'h1,
		DSPR_QTY_FREQ = 2'h2,
		DSPR_QTY_PHASE = 2'h3
	} dspr_qty_t;

	typedef enum logic [1:0] {
		DSPR_LVL_2 = 2'h0,
		DSPR_LVL_4 = 2'h1,
		DSPR_LVL_8 = 2'h2,
		DSPR_LVL_16 = 2'h3
	} dspr_lvl_t;

	// axi write fsm, one-hot
	typedef enum logic [2:0] {
		DSPR_WR_IDLE = 3'b001,
		DSPR_WR_RESP = 3'b010,
		DSPR_WR_HOLD = 3'b100
	} dspr_wst_t;

	// per-channel sweep registers
	typedef struct packed {
		logic [31:0] chan_fn; // channel function reg
		logic [15:0] interval; // rising [7:0], falling [15:8]
		logic [31:0] rise_step; // rising step word
		logic [31:0] fall_step; // falling step word
		logic [31:0] start_val; // sweep start value
		logic [31:0] end_val; // sweep end value
	} dspr_chregs_t;

	// ramp control per channel
	typedef struct packed {
		logic valid; // ramp control owned by this path
		logic down; // 1 ramp down, 0 ramp up
	} dspr_ramp_t;

endpackage : dspr_pkg

//--- verification/dspr_host_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// host controller driving profile, aux and update lines
// ------------------------------------------------------------
module dspr_host_model
	import dspr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] req_profile, // wanted profile levels
	input wire logic [2:0] req_aux, // wanted aux levels
	input wire logic req_update, // wanted update pulse
	output logic [3:0] profile_line,
	output logic [2:0] aux_line,
	output logic update_strobe
);
	// lines move just after the edge and rest low during reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			profile_line <= 4'h0;
			aux_line <= 3'h0;
			update_strobe <= 1'b0;
		end
		else
		begin
			profile_line <= req_profile;
			aux_line <= req_aux;
			update_strobe <= req_update;
		end
	end
endmodule : dspr_host_model

//--- verification/tb.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// testbench top
// ------------------------------------------------------------
module tb
	import dspr_pkg::*;
;
	logic aclk = 0, aresetn = 0; // clock and sync reset
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic awready, wready, bvalid, arready, rvalid, serial_one_bit;
	logic [1:0] bresp, rresp, resp;
	logic [3:0] req_profile = 4'h0, profile_line;
	logic [2:0] req_aux = 3'h0, aux_line;
	logic req_update = 0, update_strobe;
	logic [3:0][31:0] sweep_word;
	logic [3:0][3:0] profile_index;
	logic [3:0] ramp_active, ramp_down;
	logic [31:0] rd;
	int err_count = 0, total_checks = 0;

	always #25 aclk = ~aclk; // 20 MHz

	dspr_sweep_top dspr_sweep_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.profile_line(profile_line), .aux_line(aux_line),
		.update_strobe(update_strobe), .sweep_word(sweep_word),
		.profile_index(profile_index), .ramp_active(ramp_active),
		.ramp_down(ramp_down), .serial_one_bit(serial_one_bit));

	dspr_host_model dspr_host_model_inst (.aclk(aclk), .aresetn(aresetn),
		.req_profile(req_profile), .req_aux(req_aux),
		.req_update(req_update), .profile_line(profile_line),
		.aux_line(aux_line), .update_strobe(update_strobe));

	// one compare for every 32-bit result
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// axi write: offer address and data, hold bready until bvalid
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		bit a_ok, w_ok, b_ok;
		int n;
		a_ok = 0; w_ok = 0; b_ok = 0; n = 0;
		@(posedge aclk);
		awaddr <= {idx[5:0], 2'b00}; awvalid <= 1; wdata <= d;
		wvalid <= 1; bready <= 1;
		while (!b_ok && n < 100)
		begin
			@(posedge aclk);
			n++;
			if (a_ok && w_ok && bvalid === 1'b1)
			begin
				resp = bresp; bready <= 0; b_ok = 1;
			end
			if (!a_ok && awready === 1'b1)
			begin
				awvalid <= 0; a_ok = 1;
			end
			if (!w_ok && wready === 1'b1)
			begin
				wvalid <= 0; w_ok = 1;
			end
		end
		if (!b_ok) err_count++;
	endtask : wr

	// axi read: hold arvalid until taken, rready until rvalid
	task automatic rdr(input logic [7:0] idx);
		bit a_ok, r_ok;
		int n;
		a_ok = 0; r_ok = 0; n = 0;
		@(posedge aclk);
		araddr <= {idx[5:0], 2'b00}; arvalid <= 1; rready <= 1;
		while (!r_ok && n < 100)
		begin
			@(posedge aclk);
			n++;
			if (a_ok && rvalid === 1'b1)
			begin
				rd = rdata; resp = rresp; rready <= 0; r_ok = 1;
			end
			if (!a_ok && arready === 1'b1)
			begin
				arvalid <= 0; a_ok = 1;
			end
		end
		if (!r_ok) err_count++;
	endtask : rdr

	// ask the host model for new line levels
	task automatic lines(input logic [3:0] p, input logic [2:0] a);
		@(posedge aclk);
		req_profile <= p; req_aux <= a;
	endtask : lines

	// register reset value, readback and unmapped places
	task automatic t_regs;
		rdr(DSPR_IDX_RISE_STEP);
		check("rise step reset", DSPR_RST_WORD, rd);
		wr(DSPR_IDX_RISE_STEP, 32'ha5a5_5a5a);
		rdr(DSPR_IDX_RISE_STEP);
		check("rise step readback", 32'ha5a5_5a5a, rd);
		wr(8'h20, 32'h0000_0001);
		check("unmapped bresp", 32'h0000_0002, {30'h0, resp});
		rdr(8'h20);
		check("unmapped rresp", 32'h0000_0002, {30'h0, resp});
	endtask : t_regs

	// 2-level with aux ramp: every aux code, line n to channel n
	task automatic t_two;
		int c, ch, n;
		wr(DSPR_IDX_FUNC_ONE, 32'h0000_0c00);
		for (c = 0; c < 8; c++)
		begin
			lines(4'(c) ^ 4'ha, 3'(c));
			repeat (5) @(posedge aclk);
			ch = {c[0], c[1]};
			check("ramp owner", 32'(1 << ch), {28'h0, ramp_active});
			check("ramp dir", 32'(c[2]), {31'h0, ramp_down[ch]});
			for (n = 0; n < 4; n++)
				check("index", 32'(((c ^ 10) >> n) & 1),
					{28'h0, profile_index[n]});
			check("serial 1-bit", 32'h1, {31'h0, serial_one_bit});
		end
	endtask : t_two

	// 4-level pairs for config codes 0 to 5
	task automatic t_four;
		int pa[6] = '{0, 0, 0, 1, 1, 2};
		int pb[6] = '{1, 2, 3, 2, 3, 3};
		int p;
		logic [2:0] a;
		for (p = 0; p < 6; p++)
		begin
			a = p[0] ? 3'b110 : 3'b101;
			wr(DSPR_IDX_FUNC_ONE, 32'h0000_0d00 | (p << 12));
			lines(p[0] ? 4'b0110 : 4'b1001, a);
			repeat (5) @(posedge aclk);
			check("pair first", p[0] ? 32'h1 : 32'h2,
				{28'h0, profile_index[pa[p]]});
			check("pair second", p[0] ? 32'h2 : 32'h1,
				{28'h0, profile_index[pb[p]]});
			check("pair owners", 32'((1 << pa[p]) | (1 << pb[p])),
				{28'h0, ramp_active});
			check("dir first", 32'(a[0]), {31'h0, ramp_down[pa[p]]});
			check("dir second", 32'(a[1]), {31'h0, ramp_down[pb[p]]});
		end
	endtask : t_four

	// 16-level: low config bits pick the channel
	task automatic t_sixteen;
		int p;
		for (p = 0; p < 4; p++)
		begin
			wr(DSPR_IDX_FUNC_ONE, 32'h0000_4f00 | (p << 12));
			lines(p[0] ? 4'b0011 : 4'b0001, 3'(p[1]));
			repeat (5) @(posedge aclk);
			check("16 index", p[0] ? 32'hc : 32'h8,
				{28'h0, profile_index[p]});
			check("16 owner", 32'(1 << p), {28'h0, ramp_active});
			check("16 dir", 32'(p[1]), {31'h0, ramp_down[p]});
		end
	endtask : t_sixteen

	// follow one channel: each later change is one step, one interval
	task automatic watch(input logic [31:0] st, input int gap,
		input logic [31:0] fin);
		logic [31:0] prev;
		int since, bad, nchg;
		prev = sweep_word[1]; since = 0; bad = 0; nchg = 0;
		repeat (80)
		begin
			@(posedge aclk);
			since++;
			if (sweep_word[1] !== prev)
			begin
				if (nchg > 0 && (sweep_word[1] - prev !== st || since != gap))
					bad++;
				nchg++; since = 0; prev = sweep_word[1];
			end
		end
		check("step spacing", 32'h0, 32'(bad));
		check("step count", 32'h1, 32'(nchg >= 3));
		check("sweep final", fin, prev);
	endtask : watch

	// frequency sweep on channel 1, dwell then no-dwell
	task automatic t_sweep;
		lines(4'h0, 3'h0);
		wr(DSPR_IDX_FUNC_ONE, 32'h0000_0000);
		wr(DSPR_IDX_CHAN_SEL, 32'h0000_0001);
		wr(DSPR_IDX_CHAN_FN, 32'h0080_4000);
		wr(DSPR_IDX_START_VAL, 32'h0000_0100);
		wr(DSPR_IDX_INTERVAL, 32'h0000_0203);
		wr(DSPR_IDX_RISE_STEP, 32'h0000_0010);
		wr(DSPR_IDX_FALL_STEP, 32'h0000_0008);
		wr(DSPR_IDX_END_VAL, 32'h0000_0140);
		check("serial off", 32'h0, {31'h0, serial_one_bit});
		lines(4'b0010, 3'h0);
		watch(32'h0000_0010, 3, 32'h0000_0140);
		rdr(DSPR_IDX_STATUS);
		check("target flag", 32'h1, {31'h0, rd[9]});
		@(posedge aclk);
		req_update <= 1;
		@(posedge aclk);
		req_update <= 0;
		repeat (8) @(posedge aclk);
		check("hold after update", 32'h0000_0140, sweep_word[1]);
		check("sweep index", 32'h1, {28'h0, profile_index[1]});
		wr(DSPR_IDX_UPDATE, 32'h0000_0001);
		check("hold after sw update", 32'h0000_0140, sweep_word[1]);
		lines(4'b0000, 3'h0);
		watch(32'hffff_fff8, 2, 32'h0000_0100);
		wr(DSPR_IDX_CHAN_FN, 32'h0080_c000);
		lines(4'b0010, 3'h0);
		repeat (60) @(posedge aclk);
		check("no-dwell zero", 32'h0, sweep_word[1]);
	endtask : t_sweep

	// verdict and end of run
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	// watchdog against a hang
	initial
	begin
		repeat (6000) @(posedge aclk);
		err_count++;
		stop_test();
	end

	// main sequence
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		t_regs();
		t_two();
		t_four();
		t_sixteen();
		t_sweep();
		stop_test();
	end
endmodule : tb
